// ### design/dcc_cfg.svh
// Offsets, write masks, reset values and nanosecond timings of the
// step-up converter register block. Definitions only.
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// Register decode
`define DCC_PAGE           8'h00
`define DCC_CONFIG_ADDR    8'h96
`define DCC_CONTROL_ADDR   8'h97

// Reset values
`define DCC_CONTROL_RST    8'h21
`define DCC_CONFIG_RST     8'h00

// Writable bits; everything else is reserved or read-only
`define DCC_CONTROL_WMASK  8'hef
`define DCC_CONFIG_WMASK   8'h7f

// Clock and pulse-width timing
`define DCC_CLK_PERIOD_NS  4
`define DCC_MINPW_1_NS     20
`define DCC_MINPW_2_NS     40
`define DCC_MINPW_3_NS     80

// Divider codes: system clock divided by 1, 2, 4 and 8
`define DCC_DIV_BY1        2'h0
`define DCC_DIV_BY2        2'h1
`define DCC_DIV_BY4        2'h2
`define DCC_DIV_BY8        2'h3

// Output setpoints in millivolts, codes 0 through 7
`define DCC_MV_0           12'd1800
`define DCC_MV_1           12'd1900
`define DCC_MV_2           12'd2000
`define DCC_MV_3           12'd2100
`define DCC_MV_4           12'd2400
`define DCC_MV_5           12'd2700
`define DCC_MV_6           12'd3000
`define DCC_MV_7           12'd3300

`endif

// ### design/dcc_pkg.sv
// Types of the step-up converter register block.
// Used by name only; nothing imports it.
package dcc_pkg;

  typedef struct packed {
    logic [1:0] min_pulse_width;
    logic       switch_size_select;
    logic       rsvd;
    logic       adc_sync_en;
    logic [2:0] output_target_select;
  } dcc_ctrl_t;

  typedef struct packed {
    logic       rsvd;
    logic [1:0] converter_clock_divider;
    logic       adc_sar_clock_invert;
    logic       converter_clock_invert;
    logic       peak_current_level;
    logic       sleep_output_connect;
    logic       converter_clock_source;
  } dcc_cfg_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } dcc_sfr_req_t;

endpackage

// ### design/dcc_regs.sv
// Control and configuration registers of the on-chip step-up converter,
// with the digital steering they drive: clock divider, pulse width,
// setpoint, sleep connection and converter-synchronous sampling.
// Assumes the core's special function register port, one clock domain.
//
// Notes on behaviour
// R1: Pulse-width code sets minimum switching pulse
// R2: Bit 5 zero large switches, one small
// R3: Software zeroes sampling clock field before sync
// R4: Sync bit aligns tracking to quiet interval
// R5: Target code maps to eight output setpoints
// R6: Control at page 0, 0x97, resets 0x21
// R7: Config at page 0, 0x96, top bit read-only
// R8: Reserved bits read zero, writes ignored
// R9: Sleep bit ties output to battery or floats
// R10: Peak-current bit selects lower or higher limit
// R11: Config bit 3 inverts divider input clock
// R12: Config bit 0 selects converter clock source
`timescale 1ns/10ps
`default_nettype none
`include "dcc_cfg.svh"

module dcc_regs #(
  parameter int POS_W = 8
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [7:0] sfr_page_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // Converter status from the analog side
  input  wire logic       osc_clk_in,
  input  wire logic       sw_quiet_in,
  input  wire logic       sleep_in,
  // Converter steering
  output logic            conv_tick_out,
  output logic            conv_clk_src_osc_out,
  output logic      [4:0] min_pulse_cycles_out,
  output logic            small_switch_out,
  output logic            peak_high_out,
  output logic      [2:0] output_target_select_out,
  output logic     [11:0] target_mv_out,
  output logic            node_to_battery_out,
  output logic            node_float_out,
  // Sampling converter coupling
  output logic            adc_sync_en_out,
  output logic            adc_track_out,
  output logic            adc_sar_align_out,
  output logic            adc_sar_noninv_out
);

  localparam logic [4:0] PW1 = 5'((`DCC_MINPW_1_NS + `DCC_CLK_PERIOD_NS - 1)
                                  / `DCC_CLK_PERIOD_NS);
  localparam logic [4:0] PW2 = 5'((`DCC_MINPW_2_NS + `DCC_CLK_PERIOD_NS - 1)
                                  / `DCC_CLK_PERIOD_NS);
  localparam logic [4:0] PW3 = 5'((`DCC_MINPW_3_NS + `DCC_CLK_PERIOD_NS - 1)
                                  / `DCC_CLK_PERIOD_NS);

  dcc_pkg::dcc_sfr_req_t req;
  dcc_pkg::dcc_ctrl_t    ctrl_r, ctrl_nxt;
  dcc_pkg::dcc_cfg_t     cfg_r, cfg_nxt;
  logic [7:0]            rdata_r, rdata_nxt;
  logic                  hit_ctrl, hit_cfg;

  assign req = '{page: sfr_page_in, addr: sfr_addr_in, wr: sfr_wr_in,
                 rd: sfr_rd_in, wdata: sfr_wdata_in};
  assign hit_ctrl = (req.page == `DCC_PAGE) &&
                    (req.addr == `DCC_CONTROL_ADDR);           // [R6]
  assign hit_cfg  = (req.page == `DCC_PAGE) &&
                    (req.addr == `DCC_CONFIG_ADDR);            // [R7]

  // Register file
  always_comb begin
    ctrl_nxt  = ctrl_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (req.wr && hit_ctrl) begin
      ctrl_nxt = dcc_pkg::dcc_ctrl_t'(req.wdata &
                                      `DCC_CONTROL_WMASK);     // [R8]
    end
    if (req.wr && hit_cfg) begin
      cfg_nxt = dcc_pkg::dcc_cfg_t'(req.wdata &
                                    `DCC_CONFIG_WMASK);        // [R7] [R8]
    end
    if (req.rd) begin
      if (hit_ctrl) begin
        rdata_nxt = ctrl_r;
      end else if (hit_cfg) begin
        rdata_nxt = cfg_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_r  <= dcc_pkg::dcc_ctrl_t'(`DCC_CONTROL_RST);       // [R6]
      cfg_r   <= dcc_pkg::dcc_cfg_t'(`DCC_CONFIG_RST);         // [R7]
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Converter clock: divided system clock or internal oscillator
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic       osc_q_r, osc_q_nxt;
  logic       tick_r, tick_nxt;
  logic [2:0] div_last;
  logic [2:0] tick_phase;

  always_comb begin
    case (cfg_r.converter_clock_divider)
      `DCC_DIV_BY1: div_last = 3'h0;
      `DCC_DIV_BY2: div_last = 3'h1;
      `DCC_DIV_BY4: div_last = 3'h3;
      `DCC_DIV_BY8: div_last = 3'h7;
      default:      div_last = 3'h0;
    endcase
    // Inverted input moves the tick by half a divided period; no move when dividing by 1
    // Widened so divide-by-8 does not wrap back to phase 0
    tick_phase = cfg_r.converter_clock_invert ?
                 3'(({1'b0, div_last} + 4'h1) >> 1) : 3'h0;    // [R11]
    div_cnt_nxt = (div_cnt_r >= div_last) ? 3'h0 : 3'(div_cnt_r + 3'h1);
    osc_q_nxt   = osc_clk_in;
    if (cfg_r.converter_clock_source) begin
      tick_nxt = ((div_cnt_r & div_last) ==
                  (tick_phase & div_last));                    // [R12]
    end else begin
      tick_nxt = osc_clk_in && !osc_q_r;                       // [R12]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_cnt_r <= 3'h0;
      osc_q_r   <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      osc_q_r   <= osc_q_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // Static steering decoded from the registers
  logic [4:0]  pw_nxt;
  logic [11:0] mv_nxt;
  logic [4:0]  pw_r;
  logic [11:0] mv_r;
  logic        small_r, peak_r, src_r, batt_r, float_r;
  logic [2:0]  tsel_r;

  always_comb begin
    case (ctrl_r.min_pulse_width)                              // [R1]
      2'h0:    pw_nxt = 5'h00;
      2'h1:    pw_nxt = PW1;
      2'h2:    pw_nxt = PW2;
      2'h3:    pw_nxt = PW3;
      default: pw_nxt = 5'h00;
    endcase
    case (ctrl_r.output_target_select)                         // [R5]
      3'h0:    mv_nxt = `DCC_MV_0;
      3'h1:    mv_nxt = `DCC_MV_1;
      3'h2:    mv_nxt = `DCC_MV_2;
      3'h3:    mv_nxt = `DCC_MV_3;
      3'h4:    mv_nxt = `DCC_MV_4;
      3'h5:    mv_nxt = `DCC_MV_5;
      3'h6:    mv_nxt = `DCC_MV_6;
      3'h7:    mv_nxt = `DCC_MV_7;
      default: mv_nxt = `DCC_MV_0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pw_r    <= 5'h00;
      mv_r    <= `DCC_MV_1;
      tsel_r  <= 3'h1;
      small_r <= 1'b1;
      peak_r  <= 1'b0;
      src_r   <= 1'b1;
      batt_r  <= 1'b0;
      float_r <= 1'b0;
    end else begin
      pw_r    <= pw_nxt;
      mv_r    <= mv_nxt;
      tsel_r  <= ctrl_r.output_target_select;
      small_r <= ctrl_r.switch_size_select;                    // [R2]
      peak_r  <= cfg_r.peak_current_level;                     // [R10]
      src_r   <= !cfg_r.converter_clock_source;                // [R12]
      batt_r  <= sleep_in && !cfg_r.sleep_output_connect;      // [R9]
      float_r <= sleep_in && cfg_r.sleep_output_connect;       // [R9]
    end
  end

  // Quiet-interval tracking: learn where the longest quiet run of the
  // previous switching cycle began and track from there this cycle.
  // One cycle of history only, so a changing load lags by a cycle.
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic [POS_W-1:0] run_r, run_nxt;
  logic [POS_W-1:0] best_len_r, best_len_nxt;
  logic [POS_W-1:0] best_start_r, best_start_nxt;
  logic [POS_W-1:0] prev_start_r, prev_start_nxt;
  logic             track_r, track_nxt;
  logic             align_r, align_nxt;
  logic             sync_r, noninv_r;
  logic [POS_W-1:0] run_start;

  always_comb begin
    pos_nxt        = pos_r;
    run_nxt        = run_r;
    best_len_nxt   = best_len_r;
    best_start_nxt = best_start_r;
    prev_start_nxt = prev_start_r;
    run_start      = POS_W'(pos_r - run_r);
    if (tick_r) begin
      pos_nxt        = '0;
      run_nxt        = '0;
      best_len_nxt   = '0;
      best_start_nxt = '0;
      prev_start_nxt = best_start_r;
    end else begin
      if (pos_r != '1) begin
        pos_nxt = POS_W'(pos_r + 1'b1);
      end
      if (sw_quiet_in) begin
        if (run_r != '1) begin
          run_nxt = POS_W'(run_r + 1'b1);
        end
        if (run_nxt > best_len_r) begin
          best_len_nxt   = run_nxt;
          best_start_nxt = run_start;
        end
      end else begin
        run_nxt = '0;
      end
    end
    track_nxt = ctrl_r.adc_sync_en && sw_quiet_in && !tick_r &&
                (pos_r >= prev_start_r);                       // [R4]
    align_nxt = ctrl_r.adc_sync_en && tick_r;                  // [R4]
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pos_r        <= '0;
      run_r        <= '0;
      best_len_r   <= '0;
      best_start_r <= '0;
      prev_start_r <= '0;
      track_r      <= 1'b0;
      align_r      <= 1'b0;
      sync_r       <= 1'b0;
      noninv_r     <= 1'b1;
    end else begin
      pos_r        <= pos_nxt;
      run_r        <= run_nxt;
      best_len_r   <= best_len_nxt;
      best_start_r <= best_start_nxt;
      prev_start_r <= prev_start_nxt;
      track_r      <= track_nxt;
      align_r      <= align_nxt;
      // Sampling clock field is software's to clear before this
      sync_r       <= ctrl_r.adc_sync_en;                      // [R3] [R4]
      noninv_r     <= cfg_r.adc_sar_clock_invert;
    end
  end

  assign sfr_rdata_out            = rdata_r;
  assign conv_tick_out            = tick_r;
  assign conv_clk_src_osc_out     = src_r;
  assign min_pulse_cycles_out     = pw_r;
  assign small_switch_out         = small_r;
  assign peak_high_out            = peak_r;
  assign output_target_select_out = tsel_r;
  assign target_mv_out            = mv_r;
  assign node_to_battery_out      = batt_r;
  assign node_float_out           = float_r;
  assign adc_sync_en_out          = sync_r;
  assign adc_track_out            = track_r;
  assign adc_sar_align_out        = align_r;
  assign adc_sar_noninv_out       = noninv_r;

endmodule // dcc_regs

`default_nettype wire

// ### tb/dcc_regs_asserts.sv
// Checker for the converter register block: register port and steering.
// Bound to dcc_regs; sees its ports only, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "dcc_cfg.svh"
module dcc_regs_asserts (
  // Clock, reset and register port
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic [7:0]  sfr_page_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic [7:0]  sfr_rdata_out,
  // Sleep input and steering outputs
  input wire logic        sleep_in,
  input wire logic        conv_tick_out,
  input wire logic [4:0]  min_pulse_cycles_out,
  input wire logic        small_switch_out,
  input wire logic [2:0]  output_target_select_out,
  input wire logic [11:0] target_mv_out,
  input wire logic        node_to_battery_out,
  input wire logic        node_float_out,
  input wire logic        adc_sync_en_out,
  input wire logic        adc_track_out,
  input wire logic        adc_sar_align_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  localparam logic [11:0] MV [8] = '{12'h708, 12'h76c, 12'h7d0, 12'h834,
                                     12'h960, 12'ha8c, 12'hbb8, 12'hce4};
  function automatic logic [4:0] pw_f(input logic [1:0] c);
    return (c == 2'h0) ? 5'h00 : 5'h05 << (c - 2'h1);
  endfunction
  sequence s_wr_ctl;
    sfr_wr_in && sfr_page_in == `DCC_PAGE && sfr_addr_in == `DCC_CONTROL_ADDR;
  endsequence
  sequence s_rd(a);
    sfr_rd_in && sfr_page_in == `DCC_PAGE && sfr_addr_in == a;
  endsequence
  // Steering lags the register by one cycle, hence two edges after the write
  a_switch_size: assert property (s_wr_ctl |=> ##1
    small_switch_out == $past(sfr_wdata_in[5], 2)) else $error("switch size");
  a_target_code: assert property (s_wr_ctl |=> ##1
    output_target_select_out == $past(sfr_wdata_in[2:0], 2))
    else $error("target code");
  a_sync_enable: assert property (s_wr_ctl |=> ##1
    adc_sync_en_out == $past(sfr_wdata_in[3], 2)) else $error("sync enable");
  a_min_pulse: assert property (s_wr_ctl |=> ##1
    min_pulse_cycles_out == pw_f($past(sfr_wdata_in[7:6], 2)))
    else $error("min pulse");
  a_target_mv: assert property (
    target_mv_out == MV[output_target_select_out]) else $error("setpoint");
  a_sleep_idle: assert property (!$past(sleep_in) |->
    !node_to_battery_out && !node_float_out) else $error("node awake");
  a_node_excl: assert property (
    !(node_to_battery_out && node_float_out)) else $error("node both");
  a_rsvd_ctl: assert property (s_rd(`DCC_CONTROL_ADDR) |=>
    sfr_rdata_out[4] == 1'b0) else $error("control bit4");
  a_rsvd_cfg: assert property (s_rd(`DCC_CONFIG_ADDR) |=>
    sfr_rdata_out[7] == 1'b0) else $error("config bit7");
  a_unmapped_rd: assert property (sfr_rd_in &&
    !(sfr_page_in == `DCC_PAGE &&
      sfr_addr_in inside {`DCC_CONFIG_ADDR, `DCC_CONTROL_ADDR}) |=>
    sfr_rdata_out == 8'h00) else $error("unmapped read");
  a_rdata_hold: assert property (!sfr_rd_in |=>
    $stable(sfr_rdata_out)) else $error("rdata moved");
  a_align_tick: assert property (adc_sar_align_out |->
    $past(conv_tick_out)) else $error("align without tick");
  a_track_gated: assert property (
    adc_track_out || adc_sar_align_out |-> adc_sync_en_out)
    else $error("track without sync");
endmodule // dcc_regs_asserts
bind dcc_regs dcc_regs_asserts u_chk (.clk_sys_in, .rst_in, .sfr_page_in,
  .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
  .sleep_in, .conv_tick_out, .min_pulse_cycles_out, .small_switch_out,
  .output_target_select_out, .target_mv_out, .node_to_battery_out,
  .node_float_out, .adc_sync_en_out, .adc_track_out, .adc_sar_align_out);
`default_nettype wire

// ### tb/test_dcc_regs.sv
// Self-checking bench for the converter register block.
// Drives the register port at falling edges; oscillator stand-in
// and quiet level come from the bench as well.
`timescale 1ns/10ps
`default_nettype none
module test_dcc_regs;
  logic        clk_sys_in, rst_in, sfr_wr_in, sfr_rd_in, sleep_in;
  logic        osc_clk_in, sw_quiet_in;
  logic [7:0]  sfr_page_in, sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic        conv_tick_out, conv_clk_src_osc_out, small_switch_out;
  logic        peak_high_out, node_to_battery_out, node_float_out;
  logic        adc_sync_en_out, adc_track_out, adc_sar_align_out;
  logic        adc_sar_noninv_out;
  logic [4:0]  min_pulse_cycles_out;
  logic [2:0]  output_target_select_out;
  logic [11:0] target_mv_out;
  logic [4:0]  pw_tab [4] = '{5'h00, 5'h05, 5'h0a, 5'h14};
  int          num_errors, checks_done, cyc;
  logic [11:0] mv_tab [8] = '{12'd1800, 12'd1900, 12'd2000, 12'd2100,
                              12'd2400, 12'd2700, 12'd3000, 12'd3300};
  logic [3:0]  i;
  logic [2:0]  ph0, ph1;
  dcc_regs dut (.clk_sys_in, .rst_in, .sfr_page_in, .sfr_addr_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .osc_clk_in, .sw_quiet_in, .sleep_in, .conv_tick_out,
    .conv_clk_src_osc_out, .min_pulse_cycles_out, .small_switch_out,
    .peak_high_out, .output_target_select_out, .target_mv_out,
    .node_to_battery_out, .node_float_out, .adc_sync_en_out,
    .adc_track_out, .adc_sar_align_out, .adc_sar_noninv_out);
  always #2 clk_sys_in = ~clk_sys_in;
  // Oscillator stand-in: one rising edge every eight system clocks
  always @(negedge clk_sys_in) osc_clk_in <= cyc[2];
  task automatic results;
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      results;
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Two idle cycles after the strobe let the steering outputs settle
  task automatic wr(input logic [7:0] p, input logic [7:0] a, d);
    @(negedge clk_sys_in);
    {sfr_page_in, sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {p, a, d, 1'b1};
    @(negedge clk_sys_in);
    sfr_wr_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] a, e);
    @(negedge clk_sys_in);
    {sfr_page_in, sfr_addr_in, sfr_rd_in} = {p, a, 1'b1};
    @(negedge clk_sys_in);
    sfr_rd_in = 1'b0;
    chk({4'h0, sfr_rdata_out}, {4'h0, e});
  endtask
  // Any 32-cycle window holds a whole number of converter periods;
  // ph returns the cycle count modulo 8 at the last tick, for phase checks
  task automatic cnt(input logic [7:0] cf, ct, input logic [11:0] nt, na, nk,
                     output logic [2:0] ph);
    logic [11:0] t, n, k;
    wr(8'h00, 8'h96, cf);
    wr(8'h00, 8'h97, ct);
    repeat (8) @(negedge clk_sys_in);
    t = 12'h000;
    n = 12'h000;
    k = 12'h000;
    ph = 3'h0;
    repeat (32) begin
      @(negedge clk_sys_in);
      t += 12'(conv_tick_out);
      n += 12'(adc_sar_align_out);
      k += 12'(adc_track_out);
      if (conv_tick_out === 1'b1) ph = 3'(cyc);
    end
    chk(t, nt);
    chk(n, na);
    chk(k, nk);
  endtask
  initial begin
    {clk_sys_in, rst_in, sfr_wr_in, sfr_rd_in, sleep_in} = 5'h08;
    sw_quiet_in = 1'b1;
    {sfr_page_in, sfr_addr_in, sfr_wdata_in} = 24'h000000;
    {num_errors, checks_done, cyc} = '0;
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd(8'h00, 8'h97, 8'h21);
    rd(8'h00, 8'h96, 8'h00);
    chk(small_switch_out, 12'h001);
    wr(8'h00, 8'h97, 8'hff);
    rd(8'h00, 8'h97, 8'hef);
    wr(8'h00, 8'h96, 8'hff);
    rd(8'h00, 8'h96, 8'h7f);
    chk(peak_high_out, 12'h001);
    chk(conv_clk_src_osc_out, 12'h000);
    chk(adc_sync_en_out, 12'h001);
    chk(adc_sar_noninv_out, 12'h001);
    sleep_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk(node_float_out, 12'h001);
    wr(8'h00, 8'h96, 8'h00);
    chk(node_to_battery_out, 12'h001);
    chk(peak_high_out, 12'h000);
    chk(conv_clk_src_osc_out, 12'h001);
    chk(adc_sar_noninv_out, 12'h000);
    sleep_in = 1'b0;
    rd(8'h00, 8'h95, 8'h00);
    rd(8'h01, 8'h97, 8'h00);
    wr(8'h01, 8'h97, 8'h00);
    rd(8'h00, 8'h97, 8'hef);
    for (i = 4'h0; i < 4'h8; i++) begin
      wr(8'h00, 8'h97, {i[1:0], ~i[0], 2'b00, i[2:0]});
      chk(min_pulse_cycles_out, pw_tab[i[1:0]]);
      chk(small_switch_out, {11'h000, ~i[0]});
      chk(output_target_select_out, i[2:0]);
      chk(target_mv_out, mv_tab[i[2:0]]);
    end
    for (i = 4'h0; i < 4'h4; i++) begin
      cnt({1'b0, i[1:0], 5'h01}, 8'h21, 12'h020 >> i, 12'h000, 12'h000,
          ph0);
    end
    // Divide by 8 stays selected, so the counter phase carries over
    cnt(8'h69, 8'h21, 12'h004, 12'h000, 12'h000, ph1);
    chk({9'h000, 3'(ph1 - ph0)}, 12'h004);
    // Sampling clock field lives outside this block; taken as cleared
    cnt(8'h41, 8'h29, 12'h008, 12'h008, 12'h018, ph0);
    cnt(8'h49, 8'h21, 12'h008, 12'h000, 12'h000, ph1);
    chk({9'h000, 3'(ph1 - ph0) & 3'h3}, 12'h002);
    sw_quiet_in = 1'b0;
    cnt(8'h41, 8'h29, 12'h008, 12'h008, 12'h000, ph1);
    sw_quiet_in = 1'b1;
    cnt(8'h00, 8'h21, 12'h004, 12'h000, 12'h000, ph1);
    results;
  end
endmodule // test_dcc_regs
`default_nettype wire
